// ### pft_defs.svh
// Constants for the prescaled free-running timer
`ifndef PFT_DEFS_SVH
`define PFT_DEFS_SVH
`define PFT_ADR_CTRL     4'h0
`define PFT_ADR_IRQF     4'h1
`define PFT_ADR_IEN      4'h2
`define PFT_ADR_CNT_LO   4'h3
`define PFT_ADR_CNT_HI   4'h4
`define PFT_ADR_CAP0     4'h5
`define PFT_ADR_CMP0     4'h9
`define PFT_ADR_CMPCFG   4'hC
`define PFT_CTRL_PS0     0
`define PFT_CTRL_PS1     1
`define PFT_CTRL_MS0     2
`define PFT_CTRL_MS1     3
`define PFT_CTRL_BOVF    4
`define PFT_CTRL_XCLR    5
`define PFT_CTRL_BIS     6
`define PFT_CTRL_WIS     7
`define PFT_IRQF_WOVF    7
`define PFT_IEN_TIE      7
`define PFT_PHASES       4'd12
`define PFT_PH_FIRST     4'd3
`define PFT_PH_SECOND    4'd9
`define PFT_PH_LAST      4'd11
`define PFT_CAPS         4
`define PFT_CMPS         3
`endif

// ### pft_edge_sampler.sv
// Twice-per-cycle sampler of the external count input
`timescale 1ns/1ps
`default_nettype none
`include "pft_defs.svh"
module pft_edge_sampler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] phase,
  input  wire logic       pin,
  output logic            edge_early,
  output logic            edge_late
);
  logic last_reg;
  wire  at_first  = (phase == `PFT_PH_FIRST);
  wire  at_second = (phase == `PFT_PH_SECOND);
  // Low sample then high sample marks an edge; idle high needs no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_reg   <= 1'b1;
      edge_early <= 1'b0;
      edge_late  <= 1'b0;
    end else begin
      if (at_first || at_second) last_reg <= pin;
      edge_early <= at_first && !last_reg && pin;
      edge_late  <= at_second && !last_reg && pin;
    end
  end
endmodule
`default_nettype wire

// ### pft_pkg.sv
// Types for the prescaled free-running timer
package pft_pkg;
  typedef enum logic [1:0] {PFT_SRC_OFF, PFT_SRC_OSC, PFT_SRC_EXT} pft_src_t;
  typedef enum logic [1:0] {PFT_CMP_SET, PFT_CMP_CLR, PFT_CMP_TGL, PFT_CMP_NONE} pft_cmp_t;
endpackage

// ### pft_prescaler.sv
// Programmable divide-by-1/2/4/8 prescaler
`timescale 1ns/1ps
`default_nettype none
module pft_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [1:0] div_sel,
  output logic            pulse
);
  logic [2:0] cnt_reg;
  // Divide mask: 0, 1, 3, 7 terminal counts
  wire  [2:0] term = 3'((4'h1 << div_sel) - 4'h1);
  wire        wrap = tick && (cnt_reg == term);
  // Pulse is combinational so the count moves in the tick cycle
  assign pulse = wrap;
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_reg <= 3'h0;
    end else if (tick) begin
      cnt_reg <= wrap ? 3'h0 : cnt_reg + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### pft_pulse_src.sv
// External count and clear pulse sources driving the timer pins
`timescale 1ns/1ps
`default_nettype none
module pft_pulse_src (
  input  wire logic clk,
  output logic      count_out,
  output logic      clear_out
);
  // Both lines rest low between bursts
  initial begin
    count_out = 1'b0;
    clear_out = 1'b0;
  end
  // Minimum legal widths: half a machine cycle low, then half high
  task automatic count_pulses(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk);
      count_out <= 1'b1;
      repeat (6) @(posedge clk);
      count_out <= 1'b0;
    end
  endtask
  // One rising edge on the clear line, held a full machine cycle
  task automatic clear_pulse;
    @(posedge clk);
    clear_out <= 1'b1;
    repeat (12) @(posedge clk);
    clear_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### pft_timer.sv
// Prescaled free-running 16-bit timer with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "pft_defs.svh"
module pft_timer (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [5:2]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   idle_mode,
  input  wire logic                   external_count_input,
  input  wire logic                   external_timer_clear_input,
  input  wire logic [`PFT_CAPS-1:0]   capture_inputs,
  output logic      [7:0]             port4_out,
  output logic                        timer_irq,
  output pft_pkg::pft_src_t           clock_source
);
  import pft_pkg::*;

  // Register state
  logic [7:0]  timer_control_register_reg;
  logic        word_overflow_flag_reg;
  logic        timer_interrupt_enable_reg;
  logic [7:0]  count_low_byte_reg;
  logic [7:0]  count_high_byte_reg;
  logic [3:0]  phase_reg;
  logic        xclr_last_reg;
  logic        carry_lo_reg;
  logic        carry_hi_reg;
  logic        late_pend_reg;
  logic        early_pend_reg;
  logic [1:0]  div_last_reg;
  pft_src_t    src_last_reg;
  logic [15:0] cap_reg [`PFT_CAPS];
  logic [`PFT_CAPS-1:0] cap_last_reg;
  logic [15:0] cmp_reg [`PFT_CMPS];
  logic [5:0]  cmp_cfg_reg;
  logic [7:0]  port4_reg;
  logic        ack_reg;

  // Bus decode
  wire bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl  = bus_wr && (wb_adr_i == `PFT_ADR_CTRL);
  wire wr_irqf  = bus_wr && (wb_adr_i == `PFT_ADR_IRQF);
  wire wr_ien   = bus_wr && (wb_adr_i == `PFT_ADR_IEN);
  wire wr_cfg   = bus_wr && (wb_adr_i == `PFT_ADR_CMPCFG);
  wire [15:0] count = {count_high_byte_reg, count_low_byte_reg};

  // Source decode from the two source select bits
  function automatic pft_src_t src_of(input logic [7:0] c);
    case ({c[`PFT_CTRL_MS1], c[`PFT_CTRL_MS0]})
      2'b01:   src_of = PFT_SRC_OSC;
      2'b10,
      2'b11:   src_of = PFT_SRC_EXT;
      default: src_of = PFT_SRC_OFF;
    endcase
  endfunction

  wire pft_src_t src = src_of(timer_control_register_reg);
  wire [1:0] div_sel = {timer_control_register_reg[`PFT_CTRL_PS1],
                        timer_control_register_reg[`PFT_CTRL_PS0]};
  wire xclr_edge = timer_control_register_reg[`PFT_CTRL_XCLR] &&
                   external_timer_clear_input && !xclr_last_reg;
  wire cfg_change = (div_sel != div_last_reg) || (src != src_last_reg);
  wire presc_clr  = idle_mode || xclr_edge || cfg_change;
  assign clock_source = src;

  // Machine cycle phase counter: twelve clocks per machine cycle
  wire cycle_end = (phase_reg == `PFT_PH_LAST);
  always_ff @(posedge clk) begin
    if (!rst_n) phase_reg <= 4'h0;
    else phase_reg <= cycle_end ? 4'h0 : phase_reg + 4'h1;
  end

  logic edge_early;
  logic edge_late;
  pft_edge_sampler u_smp (
    .clk        (clk),
    .rst_n      (rst_n),
    .phase      (phase_reg),
    .pin        (external_count_input),
    .edge_early (edge_early),
    .edge_late  (edge_late)
  );

  // Edge scheduling: early edge counts at next cycle boundary, late one a cycle later
  wire ext_tick = (src == PFT_SRC_EXT) && cycle_end && early_pend_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || src != PFT_SRC_EXT) begin
      early_pend_reg <= 1'b0;
      late_pend_reg  <= 1'b0;
    end else begin
      if (cycle_end) early_pend_reg <= late_pend_reg;
      else if (edge_early) early_pend_reg <= 1'b1;
      if (cycle_end) late_pend_reg <= 1'b0;
      else if (edge_late) late_pend_reg <= 1'b1;
    end
  end

  wire osc_tick = (src == PFT_SRC_OSC) && cycle_end;
  wire tick = (osc_tick || ext_tick) && !idle_mode;
  logic presc_pulse;
  pft_prescaler u_psc (
    .clk     (clk),
    .rst_n   (rst_n),
    .clr     (presc_clr),
    .tick    (tick),
    .div_sel (div_sel),
    .pulse   (presc_pulse)
  );

  // Counter: increments per prescaler pulse, wraps, cleared by idle or ext clear
  wire inc       = presc_pulse && !presc_clr;
  wire lo_wrap   = inc && (count_low_byte_reg == 8'hFF);
  wire hi_wrap   = lo_wrap && (count_high_byte_reg == 8'hFF);
  always_ff @(posedge clk) begin
    if (!rst_n || idle_mode || xclr_edge) begin
      count_low_byte_reg  <= 8'h00;
      count_high_byte_reg <= 8'h00;
    end else if (inc) begin
      count_low_byte_reg <= count_low_byte_reg + 8'h01;
      if (lo_wrap) count_high_byte_reg <= count_high_byte_reg + 8'h01;
    end
  end

  // Overflow delay stage, bookkeeping of last config and clear pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_lo_reg  <= 1'b0;
      carry_hi_reg  <= 1'b0;
      xclr_last_reg <= 1'b0;
      div_last_reg  <= 2'h0;
      src_last_reg  <= PFT_SRC_OFF;
    end else begin
      carry_lo_reg  <= lo_wrap;
      carry_hi_reg  <= hi_wrap;
      xclr_last_reg <= external_timer_clear_input;
      div_last_reg  <= div_sel;
      src_last_reg  <= src;
    end
  end

  // Control and flags: hardware set wins over software clear
  wire [7:0] ctrl_wr = wb_dat_i[7:0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_control_register_reg <= 8'h00;
      word_overflow_flag_reg     <= 1'b0;
      timer_interrupt_enable_reg <= 1'b0;
    end else begin
      if (wr_ctrl) timer_control_register_reg <= ctrl_wr;
      if (carry_lo_reg) timer_control_register_reg[`PFT_CTRL_BOVF] <= 1'b1;
      if (wr_irqf) word_overflow_flag_reg <= wb_dat_i[`PFT_IRQF_WOVF];
      if (carry_hi_reg) word_overflow_flag_reg <= 1'b1;
      if (wr_ien) timer_interrupt_enable_reg <= wb_dat_i[`PFT_IEN_TIE];
    end
  end

  // Single shared request line for both overflow sources
  wire byte_req = timer_interrupt_enable_reg && timer_control_register_reg[`PFT_CTRL_BIS] &&
                  timer_control_register_reg[`PFT_CTRL_BOVF];
  wire word_req = timer_interrupt_enable_reg && timer_control_register_reg[`PFT_CTRL_WIS] &&
                  word_overflow_flag_reg;
  assign timer_irq = byte_req || word_req;

  // Capture: copy count on any transition of the associated pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_last_reg <= '0;
      for (int i = 0; i < `PFT_CAPS; i++) cap_reg[i] <= 16'h0000;
    end else begin
      cap_last_reg <= capture_inputs;
      for (int i = 0; i < `PFT_CAPS; i++)
        if (capture_inputs[i] != cap_last_reg[i]) cap_reg[i] <= count;
    end
  end

  // Compare: on match set, clear or toggle one port 4 pin each
  function automatic logic cmp_apply(input logic cur, input logic [1:0] act);
    case (pft_cmp_t'(act))
      PFT_CMP_SET: cmp_apply = 1'b1;
      PFT_CMP_CLR: cmp_apply = 1'b0;
      PFT_CMP_TGL: cmp_apply = !cur;
      default:     cmp_apply = cur;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port4_reg   <= 8'h00;
      cmp_cfg_reg <= 6'h3F;
      for (int i = 0; i < `PFT_CMPS; i++) cmp_reg[i] <= 16'h0000;
    end else begin
      if (wr_cfg) cmp_cfg_reg <= wb_dat_i[5:0];
      for (int i = 0; i < `PFT_CMPS; i++) begin
        if (bus_wr && wb_adr_i == `PFT_ADR_CMP0 + 4'(i)) cmp_reg[i] <= wb_dat_i[15:0];
        if (inc && count == cmp_reg[i])
          port4_reg[i] <= cmp_apply(port4_reg[i], cmp_cfg_reg[2*i +: 2]);
      end
    end
  end
  assign port4_out = port4_reg;

  // Read mux; unmapped addresses read zero but still acknowledge
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `PFT_ADR_CTRL:   rd_mux = {24'h0, timer_control_register_reg};
      `PFT_ADR_IRQF:   rd_mux = {24'h0, word_overflow_flag_reg, 7'h0};
      `PFT_ADR_IEN:    rd_mux = {24'h0, timer_interrupt_enable_reg, 7'h0};
      `PFT_ADR_CNT_LO: rd_mux = {24'h0, count_low_byte_reg};
      `PFT_ADR_CNT_HI: rd_mux = {24'h0, count_high_byte_reg};
      `PFT_ADR_CMPCFG: rd_mux = {26'h0, cmp_cfg_reg};
      default: begin
        for (int i = 0; i < `PFT_CAPS; i++)
          if (wb_adr_i == `PFT_ADR_CAP0 + 4'(i)) rd_mux = {16'h0, cap_reg[i]};
        for (int i = 0; i < `PFT_CMPS; i++)
          if (wb_adr_i == `PFT_ADR_CMP0 + 4'(i)) rd_mux = {16'h0, cmp_reg[i]};
      end
    endcase
  end

  // One-cycle registered ack and data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req;
      if (bus_req) wb_dat_o <= rd_mux;
    end
  end
  assign wb_ack_o = ack_reg;

  // Checks: flags land two edges after the wrap, through the delay stage
  sequence s_byte_late;
    ##1 timer_control_register_reg[`PFT_CTRL_BOVF];
  endsequence
  sequence s_word_late;
    ##1 (word_overflow_flag_reg && timer_control_register_reg[`PFT_CTRL_BOVF]);
  endsequence
  property p_byte_flag;
    @(posedge clk) disable iff (!rst_n) lo_wrap |=> s_byte_late;
  endproperty
  a_byte_flag: assert property (p_byte_flag) else $error("byte flag missed");
  property p_word_flag;
    @(posedge clk) disable iff (!rst_n) hi_wrap |=> s_word_late;
  endproperty
  a_word_flag: assert property (p_word_flag) else $error("word flag missed");
  // Edge to count latency: early edge seen at phase 4, late edge at phase 10
  sequence s_early_count;
    ##7 (ext_tick || src != PFT_SRC_EXT);
  endsequence
  sequence s_late_count;
    ##13 (ext_tick || src != PFT_SRC_EXT);
  endsequence
  property p_early;
    @(posedge clk) disable iff (!rst_n) (edge_early && src == PFT_SRC_EXT) |-> s_early_count;
  endproperty
  a_early: assert property (p_early) else $error("early edge not counted");
  property p_late;
    @(posedge clk) disable iff (!rst_n) (edge_late && src == PFT_SRC_EXT) |-> s_late_count;
  endproperty
  a_late: assert property (p_late) else $error("late edge not counted");
  // Bus answer: exactly one cycle after the request, one cycle wide
  property p_ack_answer;
    @(posedge clk) disable iff (!rst_n) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // Prescaler clearing on config change, idle and external clear
  property p_cfg_psc;
    @(posedge clk) disable iff (!rst_n) cfg_change |=> u_psc.cnt_reg == 3'h0;
  endproperty
  a_cfg_psc: assert property (p_cfg_psc) else $error("prescaler kept on change");
  property p_idle_psc;
    @(posedge clk) disable iff (!rst_n) idle_mode |=> u_psc.cnt_reg == 3'h0;
  endproperty
  a_idle_psc: assert property (p_idle_psc) else $error("prescaler runs in idle");
  property p_xclr_psc;
    @(posedge clk) disable iff (!rst_n) xclr_edge |=> u_psc.cnt_reg == 3'h0;
  endproperty
  a_xclr_psc: assert property (p_xclr_psc) else $error("prescaler kept on clear");
  // Source selection and stopped timer
  property p_src_osc;
    @(posedge clk) disable iff (!rst_n)
      ({timer_control_register_reg[`PFT_CTRL_MS1], timer_control_register_reg[`PFT_CTRL_MS0]}
        == 2'b01) |-> clock_source == PFT_SRC_OSC;
  endproperty
  a_src_osc: assert property (p_src_osc) else $error("source 01 not osc");
  property p_stop;
    @(posedge clk) disable iff (!rst_n) (src == PFT_SRC_OFF) |-> !inc;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer counted");
  // Count steps by one and ignores bus writes
  property p_inc_step;
    @(posedge clk) disable iff (!rst_n) inc |=> count == 16'($past(count) + 16'h0001);
  endproperty
  a_inc_step: assert property (p_inc_step) else $error("count step wrong");
  property p_no_write;
    @(posedge clk) disable iff (!rst_n)
      (bus_wr && wb_adr_i == `PFT_ADR_CNT_LO && !inc && !presc_clr) |=> $stable(count);
  endproperty
  a_no_write: assert property (p_no_write) else $error("count was written");
  // Capture copies the count seen at the transition
  property p_capture;
    @(posedge clk) disable iff (!rst_n) $changed(capture_inputs[0]) |=> cap_reg[0] == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");
  property p_compare;
    @(posedge clk) disable iff (!rst_n)
      (inc && count == cmp_reg[0] && cmp_cfg_reg[1:0] == 2'b00) |=> port4_reg[0];
  endproperty
  a_compare: assert property (p_compare) else $error("compare set missed");
  // Enabled and flagged sources must raise the shared line
  property p_byte_irq;
    @(posedge clk) disable iff (!rst_n)
      (timer_interrupt_enable_reg && timer_control_register_reg[`PFT_CTRL_BIS] &&
       timer_control_register_reg[`PFT_CTRL_BOVF]) |-> timer_irq;
  endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("byte irq missing");
  property p_word_irq;
    @(posedge clk) disable iff (!rst_n)
      (timer_interrupt_enable_reg && timer_control_register_reg[`PFT_CTRL_WIS] &&
       word_overflow_flag_reg) |-> timer_irq;
  endproperty
  a_word_irq: assert property (p_word_irq) else $error("word irq missing");
  property p_idle_clear;
    @(posedge clk) disable iff (!rst_n) idle_mode |=> count == 16'h0000;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle not cleared");
  property p_xclr;
    @(posedge clk) disable iff (!rst_n) (xclr_edge && !idle_mode) |=> count == 16'h0000;
  endproperty
  a_xclr: assert property (p_xclr) else $error("ext clear missed");
  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      timer_irq |-> timer_interrupt_enable_reg &&
        (timer_control_register_reg[`PFT_CTRL_BIS] || timer_control_register_reg[`PFT_CTRL_WIS]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");
  property p_sticky;
    @(posedge clk) disable iff (!rst_n) (word_overflow_flag_reg && !wr_irqf) |=> word_overflow_flag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag self-cleared");
  property p_wrap;
    @(posedge clk) disable iff (!rst_n) (hi_wrap && !presc_clr) |=> count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_osc_rate;
    @(posedge clk) disable iff (!rst_n) inc |-> cycle_end;
  endproperty
  a_osc_rate: assert property (p_osc_rate) else $error("count off cycle end");
endmodule
`default_nettype wire

// ### tb_prescaled_free_running_timer.sv
// Self-checking bench for the prescaled free-running timer
`timescale 1ns/1ps
`default_nettype none
`include "pft_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_prescaled_free_running_timer;
  import pft_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0;
  logic [5:2] adr = 4'h0;
  logic [3:0] sel = 4'h0, capt = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic ack, irq, ext_cnt, ext_clr;
  logic [7:0] port4, a;
  logic [15:0] v;
  pft_src_t src;
  int n_fail = 0, cmp_count = 0;
  pft_timer pft_timer_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .idle_mode(idle), .external_count_input(ext_cnt),
    .external_timer_clear_input(ext_clr), .capture_inputs(capt), .port4_out(port4),
    .timer_irq(irq), .clock_source(src));
  pft_pulse_src pft_pulse_src_inst (.clk(clk), .count_out(ext_cnt), .clear_out(ext_clr));
  // 20 MHz machine clock
  always #25 clk = ~clk;
  // Classic single cycle; leading edge leaves the bus idle one cycle
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hF};
    adr <= ad;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog sized well above the whole sequence
  initial begin
    wt(40000);
    n_fail++;
    end_sim();
  end
  initial begin
    wt(20);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wb(0, i[3:0], 0);
      `CHK("reset reg", 32'h0, rdat)
    end
    wb(0, 4'hD, 0);
    `CHK("unmapped", 32'h0, rdat)
    wb(1, `PFT_ADR_CNT_LO, 32'h55);
    wt(30);
    wb(0, `PFT_ADR_CNT_LO, 0);
    `CHK("count ro", 8'h00, rdat[7:0])
    `CHK("source off", PFT_SRC_OFF, src)
    // Windows of 96 machine cycles hold a whole number of outputs
    for (int d = 0; d < 4; d++) begin
      wb(1, `PFT_ADR_CTRL, 32'h04 | d);
      `CHK("source osc", PFT_SRC_OSC, src)
      wb(0, `PFT_ADR_CNT_LO, 0);
      a = rdat[7:0];
      wt(1149);
      wb(0, `PFT_ADR_CNT_LO, 0);
      `CHK("osc rate", 8'(a + (96 >> d)), rdat[7:0])
    end
    idle <= 1'b1;
    wt(50);
    wb(0, `PFT_ADR_CNT_LO, 0);
    `CHK("idle low", 8'h00, rdat[7:0])
    wb(0, `PFT_ADR_CNT_HI, 0);
    `CHK("idle high", 8'h00, rdat[7:0])
    idle <= 1'b0;
    wb(1, `PFT_ADR_IEN, 32'h80);
    wb(1, `PFT_ADR_CTRL, 32'h44);
    wt(3200);
    wb(0, `PFT_ADR_CTRL, 0);
    `CHK("byte flag", 1'b1, rdat[`PFT_CTRL_BOVF])
    wb(0, `PFT_ADR_CNT_HI, 0);
    `CHK("carry", 8'h01, rdat[7:0])
    `CHK("byte irq", 1'b1, irq)
    wb(1, `PFT_ADR_CTRL, 32'h44);
    wt(1);
    `CHK("byte irq off", 1'b0, irq)
    wb(1, `PFT_ADR_IRQF, 32'h80);
    wb(1, `PFT_ADR_CTRL, 32'h84);
    wt(1);
    `CHK("word irq", 1'b1, irq)
    wb(0, `PFT_ADR_IRQF, 0);
    `CHK("word flag kept", 1'b1, rdat[`PFT_IRQF_WOVF])
    wb(1, `PFT_ADR_IEN, 32'h0);
    wt(1);
    `CHK("irq masked", 1'b0, irq)
    // Capture with the count frozen so every copy is predictable
    wb(1, `PFT_ADR_CTRL, 32'h0);
    wb(0, `PFT_ADR_CNT_LO, 0);
    v[7:0] = rdat[7:0];
    wb(0, `PFT_ADR_CNT_HI, 0);
    v[15:8] = rdat[7:0];
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      capt[i] <= 1'b1;
      wt(5);
      wb(0, `PFT_ADR_CAP0 + i[3:0], 0);
      `CHK("capture", v, rdat[15:0])
    end
    wb(1, `PFT_ADR_CMP0, 32'(v + 16'd20));
    wb(1, `PFT_ADR_CMPCFG, 32'h3C);
    `CHK("port4 idle", 8'h00, port4)
    wb(1, `PFT_ADR_CTRL, 32'h04);
    wt(300);
    `CHK("compare set", 8'h01, port4)
    // External pulses at divide 1, then divide 2
    for (int d = 0; d < 2; d++) begin
      wb(1, `PFT_ADR_CTRL, 32'h08 | d);
      wb(0, `PFT_ADR_CNT_LO, 0);
      a = rdat[7:0];
      pft_pulse_src_inst.count_pulses(20);
      wt(40);
      wb(0, `PFT_ADR_CNT_LO, 0);
      `CHK("ext count", 8'(a + (20 >> d)), rdat[7:0])
    end
    wb(1, `PFT_ADR_CTRL, 32'h08);
    pft_pulse_src_inst.clear_pulse();
    wt(5);
    wb(0, `PFT_ADR_CNT_LO, 0);
    `CHK("clear disabled", 8'(a + 8'd10), rdat[7:0])
    wb(1, `PFT_ADR_CTRL, 32'h29);
    pft_pulse_src_inst.count_pulses(1);
    wt(40);
    pft_pulse_src_inst.clear_pulse();
    wt(5);
    wb(0, `PFT_ADR_CNT_HI, 0);
    `CHK("clear high", 8'h00, rdat[7:0])
    pft_pulse_src_inst.count_pulses(1);
    wt(40);
    wb(0, `PFT_ADR_CNT_LO, 0);
    `CHK("prescaler cleared", 8'h00, rdat[7:0])
    pft_pulse_src_inst.count_pulses(1);
    wt(40);
    wb(0, `PFT_ADR_CNT_LO, 0);
    `CHK("after clear", 8'h01, rdat[7:0])
    end_sim();
  end
endmodule
`default_nettype wire
